// ==== common/vseq_pkg.sv ====
// constants and types shared by the vertical region sequencer and its waveform generators
package vseq_pkg;

  // counts of the resources in the region sequencer
  localparam int NUM_REGIONS = 5;
  localparam int NUM_VOUT    = 4;
  localparam int NUM_SEQ     = 12;
  localparam int NUM_AREAS   = 8;

  // field widths
  localparam int POS_W  = 12;
  localparam int PTR_W  = 4;
  localparam int TOG_W  = 10;
  localparam int AREA_W = 3;

  typedef logic [POS_W-1:0]  pos_t;
  typedef logic [PTR_W-1:0]  ptr_t;
  typedef logic [TOG_W-1:0]  tog_t;
  typedef logic [AREA_W-1:0] area_t;

  // largest legal sequence number and region number
  localparam ptr_t  MAX_SEQ_IDX    = 4'hb;
  localparam area_t MAX_REGION_IDX = 3'h4;

  // a 12-bit line length of zero stands for the 4096-pixel maximum
  localparam int   MAX_LINE_PIXELS = 4096;
  localparam pos_t POS_ONE         = 12'h001;
  localparam tog_t TOG_ONE         = 10'h001;

  // reset values
  localparam pos_t  PIXEL_RST  = 12'h000;
  localparam pos_t  LINE_RST   = 12'h000;
  localparam pos_t  LEN_RST    = 12'h000;
  localparam area_t AREA_RST   = 3'h0;
  localparam ptr_t  SEL_RST    = 4'hf;
  localparam logic [NUM_VOUT-1:0] VCLK_RST = 4'h0;

endpackage

// ==== common/seq_if.sv ====
// carrier between the region sequencer and one sequence waveform generator
`timescale 1ns/10ps
interface seq_if;
  import vseq_pkg::*;
  logic ce;
  pos_t pixel;
  pos_t start;
  logic pol;
  tog_t tog1;
  tog_t tog2;
  tog_t rep_len;
  pos_t rep;
  logic wave;

  modport ctrl (
    output ce,
    output pixel,
    output start,
    output pol,
    output tog1,
    output tog2,
    output rep_len,
    output rep,
    input  wave
  );

  modport gen (
    input  ce,
    input  pixel,
    input  start,
    input  pol,
    input  tog1,
    input  tog2,
    input  rep_len,
    input  rep,
    output wave
  );
endinterface

// ==== design/seq_wave_gen.sv ====
// one pulse sequence placed at a start pixel, with repeats, for one vertical output
`timescale 1ns/10ps
module seq_wave_gen
  import vseq_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // sequence parameters and level
  seq_if.gen       bus
);

  logic started_ff;
  logic nxt_started;
  tog_t phase_ff;
  tog_t nxt_phase;
  pos_t reps_ff;
  pos_t nxt_reps;
  logic hit;
  logic running;
  tog_t ph;
  pos_t reps_now;

  always_comb begin
    hit         = (bus.pixel == bus.start);
    ph          = hit ? '0 : phase_ff;
    reps_now    = hit ? '0 : reps_ff;
    // a repeat count of zero never runs, so the level stays at the start polarity
    running     = (hit || started_ff) && (reps_now < bus.rep); // R15
    nxt_started = started_ff;
    nxt_phase   = phase_ff;
    nxt_reps    = reps_ff;
    if (hit) begin
      nxt_started = 1'b1;
      nxt_reps    = '0;
      nxt_phase   = '0;
    end else if (bus.pixel == PIXEL_RST) begin
      nxt_started = 1'b0;
    end
    if (running) begin
      // a repeat length of zero wraps after 1024 pixels
      if (ph == tog_t'(bus.rep_len - TOG_ONE)) begin
        nxt_phase = '0;
        nxt_reps  = pos_t'(reps_now + POS_ONE);
      end else begin
        nxt_phase = tog_t'(ph + TOG_ONE);
      end
    end
    // toggles are 10-bit offsets from the start of the sequence
    bus.wave = running ? (bus.pol ^ ((ph >= bus.tog1) && (ph < bus.tog2))) : bus.pol; // R16
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      started_ff <= 1'b0;
      phase_ff   <= '0;
      reps_ff    <= '0;
    end else if (bus.ce) begin
      started_ff <= nxt_started;
      phase_ff   <= nxt_phase;
      reps_ff    <= nxt_reps;
    end
  end

endmodule

// ==== design/vert_region_seq.sv ====
// vertical clock region sequencer: line/field counting, region areas and sequence routing to four outputs
`timescale 1ns/10ps

// Contract
// R1 - each of five regions has its own 12-bit line length, at most 4096 pixels
// R2 - every output in every region has its own 12-bit start position
// R3 - the last line of a field uses the separate final line length
// R4 - per region and output a first-line pointer picks one of twelve sequences
// R5 - a set first-line invert bit drives the selected sequence inverted
// R6 - a pointer above eleven holds the output at its invert bit level
// R7 - area boundaries are line numbers: first fixed at zero, seven programmable
// R8 - each of eight areas has a 3-bit pointer choosing one of five regions
// R9 - alternation bit set: alternate first and second settings line by line
// R10 - alternation bit clear: second-line pointers ignored, first used every line
// R11 - a set second-line invert bit inverts the second-line sequence
// R12 - gate-line enable adds a second sequence set on the sensor-gate line only
// R13 - a gate line starts with the sequences of the preceding line
// R14 - gate-line set has own start, pointer and invert per output
// R15 - repeat count zero gives constant start polarity, one gives one pulse
// R16 - toggle positions are 10-bit offsets within the sequence
// R17 - line counter restarts each field, pixel counter each line
// R18 - an area takes effect from the first pixel of its boundary line
module vert_region_seq
  import vseq_pkg::*;
(
  // clock, reset, clock enable
  input  wire logic                                    i_clk,
  input  wire logic                                    i_sys_rst,
  input  wire logic                                    i_ce,
  // field timing, from logic on the same clock
  input  wire logic                                    i_field_start,
  input  wire logic                                    i_sensor_gate_line,
  // per region settings
  input  wire pos_t  [NUM_REGIONS-1:0]                 i_region_line_length,
  input  wire pos_t  [NUM_REGIONS-1:0][NUM_VOUT-1:0]   i_output_start_position,
  input  wire ptr_t  [NUM_REGIONS-1:0][NUM_VOUT-1:0]   i_first_line_seq_select,
  input  wire logic  [NUM_REGIONS-1:0][NUM_VOUT-1:0]   i_first_line_invert,
  input  wire ptr_t  [NUM_REGIONS-1:0][NUM_VOUT-1:0]   i_second_line_seq_select,
  input  wire logic  [NUM_REGIONS-1:0][NUM_VOUT-1:0]   i_second_line_invert,
  input  wire logic  [NUM_REGIONS-1:0]                 i_line_alternate_enable,
  // field layout
  input  wire pos_t                                    i_final_line_length,
  input  wire pos_t                                    i_final_line_index,
  input  wire pos_t  [NUM_AREAS-1:1]                   i_region_change_line,
  input  wire area_t [NUM_AREAS-1:0]                   i_region_area_select,
  // sensor gate line second set
  input  wire logic                                    i_gate_line_extra_enable,
  input  wire pos_t  [NUM_VOUT-1:0]                    i_gate_line_start_pos,
  input  wire ptr_t  [NUM_VOUT-1:0]                    i_gate_line_seq_select,
  input  wire logic  [NUM_VOUT-1:0]                    i_gate_line_invert,
  // sequence pool
  input  wire logic  [NUM_SEQ-1:0]                     i_seq_start_pol,
  input  wire tog_t  [NUM_SEQ-1:0]                     i_seq_first_toggle,
  input  wire tog_t  [NUM_SEQ-1:0]                     i_seq_second_toggle,
  input  wire tog_t  [NUM_SEQ-1:0]                     i_seq_repeat_length,
  input  wire pos_t  [NUM_SEQ-1:0]                     i_seq_pulse_repeat_count,
  // vertical clocks
  output logic       [NUM_VOUT-1:0]                    o_vertical_clock_outputs,
  // status
  output logic                                         o_horizontal_line_sync,
  output pos_t                                         o_line_count,
  output pos_t                                         o_pixel_count,
  output area_t                                        o_region_area,
  output area_t                                        o_active_region,
  output logic                                         o_gate_line_active,
  output logic                                         o_alternate_phase
);

  // an out-of-range pointer holds the output at the invert level
  function automatic logic drive_level(input ptr_t sel, input logic inv, input logic wave);
    drive_level = (sel > MAX_SEQ_IDX) ? inv : (wave ^ inv);
  endfunction

  // pool index that is always legal; the wave is discarded when the pointer is out of range
  function automatic ptr_t safe_idx(input ptr_t sel);
    safe_idx = (sel > MAX_SEQ_IDX) ? '0 : sel;
  endfunction

  // counters and line state
  pos_t  pixel_ff;
  pos_t  nxt_pixel;
  pos_t  line_ff;
  pos_t  nxt_line;
  pos_t  len_ff;
  pos_t  nxt_len;
  area_t area_ff;
  area_t nxt_area;
  area_t region_ff;
  area_t nxt_region;
  logic  parity_ff;
  logic  nxt_parity;
  logic  gate_ff;
  logic  nxt_gate;
  logic  sync_ff;
  logic  nxt_sync;

  // per output selections latched at each line start except on gate lines
  ptr_t  [NUM_VOUT-1:0] sel_ff;
  ptr_t  [NUM_VOUT-1:0] nxt_sel;
  logic  [NUM_VOUT-1:0] inv_ff;
  logic  [NUM_VOUT-1:0] nxt_inv;
  pos_t  [NUM_VOUT-1:0] start_ff;
  pos_t  [NUM_VOUT-1:0] nxt_start;
  logic  [NUM_VOUT-1:0] vclk_ff;
  logic  [NUM_VOUT-1:0] nxt_vclk;

  // line boundary terms
  logic  line_end;
  logic  line_adv;
  pos_t  line_num_n;
  area_t area_n;
  area_t region_n;
  logic  parity_n;

  always_comb begin
    // a length of zero gives a 4096-pixel line
    line_end   = (pixel_ff == pos_t'(len_ff - POS_ONE)); // R1
    line_adv   = i_field_start || line_end;
    line_num_n = i_field_start ? LINE_RST : pos_t'(line_ff + POS_ONE); // R17
    // area zero always begins at line zero; later areas begin when their line comes up
    area_n     = i_field_start ? AREA_RST : area_ff; // R7
    for (int k = 1; k < NUM_AREAS; k++) begin
      if (!i_field_start && (i_region_change_line[k] == line_num_n)) begin
        area_n = area_t'(k); // R18
      end
    end
    // unused pointer codes fall back to region zero
    region_n   = (i_region_area_select[area_n] > MAX_REGION_IDX) ? AREA_RST
                                                                 : i_region_area_select[area_n]; // R8
    // alternation restarts on the first line of every area
    parity_n   = (i_field_start || (area_n != area_ff)) ? 1'b0 : ~parity_ff;
  end

  always_comb begin
    nxt_pixel  = pixel_ff;
    nxt_line   = line_ff;
    nxt_len    = len_ff;
    nxt_area   = area_ff;
    nxt_region = region_ff;
    nxt_parity = parity_ff;
    nxt_gate   = gate_ff;
    nxt_sel    = sel_ff;
    nxt_inv    = inv_ff;
    nxt_start  = start_ff;
    nxt_sync   = line_adv;
    if (line_adv) begin
      nxt_pixel  = PIXEL_RST; // R17
      nxt_line   = line_num_n;
      nxt_area   = area_n;
      nxt_region = region_n;
      nxt_parity = parity_n;
      nxt_gate   = i_sensor_gate_line && i_gate_line_extra_enable; // R12
      if (line_num_n == i_final_line_index) begin
        nxt_len = i_final_line_length; // R3
      end else begin
        nxt_len = i_region_line_length[region_n]; // R1
      end
      // on a gate line the first part repeats what the preceding line drove
      if (!nxt_gate) begin // R13
        for (int o = 0; o < NUM_VOUT; o++) begin
          nxt_start[o] = i_output_start_position[region_n][o]; // R2
          if (i_line_alternate_enable[region_n] && parity_n) begin // R9
            nxt_sel[o] = i_second_line_seq_select[region_n][o];
            nxt_inv[o] = i_second_line_invert[region_n][o]; // R11
          end else begin // R10
            nxt_sel[o] = i_first_line_seq_select[region_n][o]; // R4
            nxt_inv[o] = i_first_line_invert[region_n][o]; // R5
          end
        end
      end
    end else begin
      nxt_pixel = pos_t'(pixel_ff + POS_ONE);
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pixel_ff  <= PIXEL_RST;
      line_ff   <= LINE_RST;
      len_ff    <= LEN_RST;
      area_ff   <= AREA_RST;
      region_ff <= AREA_RST;
      parity_ff <= 1'b0;
      gate_ff   <= 1'b0;
      sync_ff   <= 1'b0;
      for (int o = 0; o < NUM_VOUT; o++) begin
        sel_ff[o]   <= SEL_RST;
        inv_ff[o]   <= 1'b0;
        start_ff[o] <= PIXEL_RST;
      end
    end else if (i_ce) begin
      pixel_ff  <= nxt_pixel;
      line_ff   <= nxt_line;
      len_ff    <= nxt_len;
      area_ff   <= nxt_area;
      region_ff <= nxt_region;
      parity_ff <= nxt_parity;
      gate_ff   <= nxt_gate;
      sync_ff   <= nxt_sync;
      sel_ff    <= nxt_sel;
      inv_ff    <= nxt_inv;
      start_ff  <= nxt_start;
    end
  end

  // one generator for the line set and one for the gate-line set per output
  seq_if line_bus [NUM_VOUT] ();
  seq_if gate_bus [NUM_VOUT] ();

  generate
    for (genvar o = 0; o < NUM_VOUT; o++) begin : g_vout
      ptr_t li;
      ptr_t gi;
      logic use_gate;

      assign li = safe_idx(sel_ff[o]);
      assign gi = safe_idx(i_gate_line_seq_select[o]);

      assign line_bus[o].ce      = i_ce;
      assign line_bus[o].pixel   = pixel_ff;
      assign line_bus[o].start   = start_ff[o]; // R2
      assign line_bus[o].pol     = i_seq_start_pol[li];
      assign line_bus[o].tog1    = i_seq_first_toggle[li];
      assign line_bus[o].tog2    = i_seq_second_toggle[li];
      assign line_bus[o].rep_len = i_seq_repeat_length[li];
      assign line_bus[o].rep     = i_seq_pulse_repeat_count[li];

      assign gate_bus[o].ce      = i_ce;
      assign gate_bus[o].pixel   = pixel_ff;
      assign gate_bus[o].start   = i_gate_line_start_pos[o]; // R14
      assign gate_bus[o].pol     = i_seq_start_pol[gi];
      assign gate_bus[o].tog1    = i_seq_first_toggle[gi];
      assign gate_bus[o].tog2    = i_seq_second_toggle[gi];
      assign gate_bus[o].rep_len = i_seq_repeat_length[gi];
      assign gate_bus[o].rep     = i_seq_pulse_repeat_count[gi];

      seq_wave_gen u_line_gen (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .bus       (line_bus[o])
      );

      seq_wave_gen u_gate_gen (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .bus       (gate_bus[o])
      );

      // the second set takes the output from its own start pixel to the end of the gate line
      assign use_gate = gate_ff && (pixel_ff >= i_gate_line_start_pos[o]); // R12

      always_comb begin
        if (use_gate) begin
          nxt_vclk[o] = drive_level(i_gate_line_seq_select[o], i_gate_line_invert[o],
                                    gate_bus[o].wave); // R14
        end else begin
          nxt_vclk[o] = drive_level(sel_ff[o], inv_ff[o], line_bus[o].wave); // R6
        end
      end
    end
  endgenerate

  // outputs lag the pixel counter by one clock, a fixed offset for all four
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      vclk_ff <= VCLK_RST;
    end else if (i_ce) begin
      vclk_ff <= nxt_vclk;
    end
  end

  assign o_vertical_clock_outputs = vclk_ff;
  assign o_horizontal_line_sync   = sync_ff;
  assign o_line_count             = line_ff;
  assign o_pixel_count            = pixel_ff;
  assign o_region_area            = area_ff;
  assign o_active_region          = region_ff;
  assign o_gate_line_active       = gate_ff;
  assign o_alternate_phase        = parity_ff;

endmodule

// ==== dv/vert_region_seq_assertions.sv ====
// port assertions for the vertical region sequencer
`timescale 1ns/10ps
module vert_region_seq_assertions
  import vseq_pkg::*;
(
  // clock, reset, enable and field timing
  input wire logic                      i_clk,
  input wire logic                      i_sys_rst,
  input wire logic                      i_ce,
  input wire logic                      i_field_start,
  // line and field layout
  input wire pos_t  [NUM_REGIONS-1:0]   i_region_line_length,
  input wire pos_t                      i_final_line_length,
  input wire pos_t                      i_final_line_index,
  input wire pos_t  [NUM_AREAS-1:1]     i_region_change_line,
  input wire area_t [NUM_AREAS-1:0]     i_region_area_select,
  // outputs watched
  input wire logic  [NUM_VOUT-1:0]      o_vertical_clock_outputs,
  input wire logic                      o_horizontal_line_sync,
  input wire pos_t                      o_line_count,
  input wire pos_t                      o_pixel_count,
  input wire area_t                     o_region_area,
  input wire area_t                     o_active_region,
  input wire logic                      o_gate_line_active,
  input wire logic                      o_alternate_phase
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  pos_t  reg_last;
  pos_t  fin_last;
  area_t hit;
  area_t sel;
  logic  hit_v;

  // a zero length wraps to 4095 here, which is the last pixel of a 4096-pixel line
  always_comb begin
    reg_last = i_region_line_length[o_active_region] - POS_ONE;
    fin_last = i_final_line_length - POS_ONE;
    sel      = i_region_area_select[o_region_area];
    hit      = AREA_RST;
    hit_v    = 1'b0;
    for (int k = 1; k < NUM_AREAS; k++) begin
      if (i_region_change_line[k] == o_line_count) begin
        hit   = area_t'(k);
        hit_v = 1'b1;
      end
    end
  end

  sequence s_new_line;
    o_horizontal_line_sync && o_pixel_count == PIXEL_RST;
  endsequence

  property p_field;
    i_ce && i_field_start |=> s_new_line ##0 (o_line_count == LINE_RST && o_region_area == AREA_RST);
  endproperty
  a_field: assert property (p_field) else $error("field start did not restart counts");

  property p_sync;
    o_horizontal_line_sync |-> o_pixel_count == PIXEL_RST;
  endproperty
  a_sync: assert property (p_sync) else $error("line sync away from pixel zero");

  // the edge that releases reset still resets the counters, so it is no counting edge
  property p_count;
    !i_sys_rst && i_ce && !i_field_start |=> o_pixel_count == pos_t'($past(o_pixel_count) + POS_ONE) ||
      (o_horizontal_line_sync && o_line_count == pos_t'($past(o_line_count) + POS_ONE));
  endproperty
  a_count: assert property (p_count) else $error("pixel or line count stepped wrongly");

  property p_freeze;
    !i_ce |=> $stable(o_pixel_count) && $stable(o_line_count) && $stable(o_vertical_clock_outputs);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with enable low");

  property p_len;
    i_ce && !i_field_start && !o_gate_line_active && o_line_count != i_final_line_index
      |=> o_horizontal_line_sync == ($past(o_pixel_count) == $past(reg_last));
  endproperty
  a_len: assert property (p_len) else $error("line end not at region length");

  property p_final;
    i_ce && !i_field_start && o_line_count == i_final_line_index
      |=> o_horizontal_line_sync == ($past(o_pixel_count) == $past(fin_last));
  endproperty
  a_final: assert property (p_final) else $error("final line length not used");

  property p_area;
    o_horizontal_line_sync && o_line_count != LINE_RST && hit_v |-> o_region_area == hit;
  endproperty
  a_area: assert property (p_area) else $error("area not taken at boundary line");

  property p_hold;
    !o_horizontal_line_sync |-> $stable(o_region_area);
  endproperty
  a_hold: assert property (p_hold) else $error("area changed inside a line");

  property p_map;
    o_horizontal_line_sync |-> o_active_region == (sel > MAX_REGION_IDX ? AREA_RST : sel);
  endproperty
  a_map: assert property (p_map) else $error("wrong region for area");

  property p_alt;
    o_horizontal_line_sync && $past(i_ce) && o_line_count != LINE_RST && $stable(o_region_area)
      |-> o_alternate_phase != $past(o_alternate_phase);
  endproperty
  a_alt: assert property (p_alt) else $error("alternation phase did not toggle");
endmodule

// ==== dv/ccd_vgate_model.sv ====
// far side: vertical gate inputs recording the level seen at each pixel but the last of a line
`timescale 1ns/10ps
module ccd_vgate_model
  import vseq_pkg::*;
(
  // clock and enable
  input wire logic                i_clk,
  input wire logic                i_ce,
  // vertical clocks and line position
  input wire logic [NUM_VOUT-1:0] i_vclk,
  input wire pos_t                i_pixel
);
  // level of pixel p shows when the count reads p+1, so the last pixel is lost at the wrap
  logic [NUM_VOUT-1:0] lvl_ff [MAX_LINE_PIXELS];
  pos_t                len_ff;

  always_ff @(posedge i_clk) begin
    if (i_ce && i_pixel != PIXEL_RST) begin
      lvl_ff[i_pixel - POS_ONE] <= i_vclk;
      len_ff                    <= i_pixel + POS_ONE;
    end
  end
endmodule

// ==== dv/vert_region_seq_test.sv ====
// self-checking bench for the vertical region sequencer
`timescale 1ns/10ps
`define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("wrong value %0t %s", $time, m); end end
module vert_region_seq_test
  import vseq_pkg::*;
;
  logic                                  clk = 1'b0, rst = 1'b1, ce = 1'b1, fs = 1'b0, sgl = 1'b0, gen = 1'b0;
  pos_t  [NUM_REGIONS-1:0]               rlen = '0;
  pos_t  [NUM_REGIONS-1:0][NUM_VOUT-1:0] st = '0;
  ptr_t  [NUM_REGIONS-1:0][NUM_VOUT-1:0] s1 = '1, s2 = '1;
  logic  [NUM_REGIONS-1:0][NUM_VOUT-1:0] n1 = '0, n2 = '0;
  logic  [NUM_REGIONS-1:0]               alt = '0;
  pos_t                                  flen = '0, fidx = '0;
  pos_t  [NUM_AREAS-1:1]                 rcl = '1;
  area_t [NUM_AREAS-1:0]                 asel = '0;
  pos_t  [NUM_VOUT-1:0]                  gst = '0;
  ptr_t  [NUM_VOUT-1:0]                  gsel = '0;
  logic  [NUM_VOUT-1:0]                  ginv = '0, vclk;
  logic  [NUM_SEQ-1:0]                   spol = '0;
  tog_t  [NUM_SEQ-1:0]                   t1 = '0, t2 = '0, rl = '0;
  pos_t  [NUM_SEQ-1:0]                   rep = '0;
  logic                                  sync, gact, aph;
  pos_t                                  lc, pc;
  area_t                                 ar, arg;
  int                                    fail_count = 0, num_checks = 0;

  always #2 clk = ~clk;

  vert_region_seq dut_u (.i_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_field_start(fs), .i_sensor_gate_line(sgl),
    .i_region_line_length(rlen), .i_output_start_position(st), .i_first_line_seq_select(s1),
    .i_first_line_invert(n1), .i_second_line_seq_select(s2), .i_second_line_invert(n2),
    .i_line_alternate_enable(alt), .i_final_line_length(flen), .i_final_line_index(fidx),
    .i_region_change_line(rcl), .i_region_area_select(asel), .i_gate_line_extra_enable(gen),
    .i_gate_line_start_pos(gst), .i_gate_line_seq_select(gsel), .i_gate_line_invert(ginv),
    .i_seq_start_pol(spol), .i_seq_first_toggle(t1), .i_seq_second_toggle(t2), .i_seq_repeat_length(rl),
    .i_seq_pulse_repeat_count(rep), .o_vertical_clock_outputs(vclk), .o_horizontal_line_sync(sync),
    .o_line_count(lc), .o_pixel_count(pc), .o_region_area(ar), .o_active_region(arg),
    .o_gate_line_active(gact), .o_alternate_phase(aph));

  ccd_vgate_model mdl_u (.i_clk(clk), .i_ce(ce), .i_vclk(vclk), .i_pixel(pc));

  // level of one output from the sequence pool; before its start an output rests at start polarity xor its invert bit
  function automatic logic lvl_of(ptr_t s, logic inv, pos_t sp, pos_t p);
    int off;
    off = int'(p) - int'(sp);
    if (s > MAX_SEQ_IDX) return inv;
    if (off < 0 || rep[s] == 0 || off / rl[s] >= rep[s]) return spol[s] ^ inv;
    return spol[s] ^ inv ^ ((off % rl[s]) >= t1[s] && (off % rl[s]) < t2[s]);
  endfunction

  task automatic wrap_up();
    if (fail_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // releases reset too, so the first edge after release carries a field start
  task automatic pulse_fs();
    @(posedge clk);
    rst <= 1'b0;
    fs  <= 1'b1;
    @(posedge clk);
    fs <= 1'b0;
    #1;
    `CHK({sync, pc, lc}, {1'b1, PIXEL_RST, LINE_RST}, "field start")
  endtask

  // waits for the next line, then judges the line just ended
  task automatic line_done(int r, bit sec, int g, int len);
    logic [NUM_VOUT-1:0] e;
    int                  n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (sync !== 1'b1 && n < 5000);
    `CHK(sync, 1'b1, "line start missing")
    `CHK(mdl_u.len_ff, pos_t'(len), "line length")
    for (int p = 0; p < len - 1; p++) begin
      for (int v = 0; v < NUM_VOUT; v++) begin
        if (p >= g) e[v] = lvl_of(gsel[v], ginv[v], gst[v], pos_t'(p));
        else if (sec) e[v] = lvl_of(s2[r][v], n2[r][v], st[r][v], pos_t'(p));
        else e[v] = lvl_of(s1[r][v], n1[r][v], st[r][v], pos_t'(p));
      end
      `CHK(mdl_u.lvl_ff[p], e, "vertical level")
    end
  endtask

  task automatic t_field();
    pos_t hold;
    pulse_fs();
    line_done(0, 1'b0, 4096, 40);
    line_done(0, 1'b0, 4096, 40);
    line_done(1, 1'b0, 4096, 30);
    @(posedge clk);
    ce <= 1'b0;
    #1;
    hold = pc;
    repeat (3) @(posedge clk);
    #1;
    `CHK(pc, hold, "count moved while frozen")
    @(posedge clk);
    ce <= 1'b1;
    line_done(1, 1'b1, 4096, 30);
    line_done(1, 1'b0, 4096, 30);
    line_done(0, 1'b0, 4096, 40);
    line_done(0, 1'b0, 4096, 20);
  endtask

  task automatic t_gate();
    @(posedge clk);
    gen <= 1'b1;
    pulse_fs();
    line_done(0, 1'b0, 4096, 40);
    `CHK(gact, 1'b0, "gate line without request")
    @(posedge clk);
    sgl <= 1'b1;
    line_done(0, 1'b0, 4096, 40);
    `CHK(gact, 1'b1, "gate line not active")
    @(posedge clk);
    sgl <= 1'b0;
    // gate line opens region 1 but keeps the region 0 selections of the line before
    line_done(0, 1'b0, 20, 30);
  endtask

  initial begin
    @(posedge clk);
    rlen[0] <= 12'h028;
    rlen[1] <= 12'h01e;
    st[0]   <= {12'h00a, 12'h000, 12'h006, 12'h003};
    st[1]   <= {12'h004, 12'h002, 12'h001, 12'h000};
    s1[0]   <= {4'hd, 4'h1, 4'h0, 4'h0};
    n1[0]   <= 4'ha;
    s2[0]   <= {4{4'h1}};
    n2[0]   <= 4'hf;
    s1[1]   <= {4{4'h0}};
    s2[1]   <= {4{4'h2}};
    n2[1]   <= 4'h3;
    alt     <= 5'h02;
    flen    <= 12'h014;
    fidx    <= 12'h006;
    rcl[1]  <= 12'h002;
    rcl[2]  <= 12'h005;
    asel[1] <= 3'h1;
    asel[2] <= 3'h7;
    gst     <= {4{12'h014}};
    ginv    <= 4'h5;
    spol    <= 12'h006;
    t1[0]   <= 10'h002;
    t2[0]   <= 10'h005;
    rl[0]   <= 10'h008;
    rep[0]  <= 12'h002;
    t2[2]   <= 10'h003;
    rl[2]   <= 10'h005;
    rep[2]  <= 12'h001;
    repeat (3) @(posedge clk);
    t_field();
    t_gate();
    wrap_up();
  end

  // whole run is well under two thousand cycles
  initial begin
    #40000;
    fail_count++;
    wrap_up();
  end
endmodule

bind vert_region_seq vert_region_seq_assertions chk_u (.i_clk, .i_sys_rst, .i_ce, .i_field_start,
  .i_region_line_length, .i_final_line_length, .i_final_line_index, .i_region_change_line,
  .i_region_area_select, .o_vertical_clock_outputs, .o_horizontal_line_sync, .o_line_count,
  .o_pixel_count, .o_region_area, .o_active_region, .o_gate_line_active, .o_alternate_phase);
